// file: hw/cprf_pkg.sv
package cprf_pkg;
  localparam int CLK_PERIOD_NS = 4;
  // least width of the refresh strobe, rounded up to whole cycles
  localparam int REFR_TIME_NS = 8;
  localparam int REFR_CYC = (REFR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // register byte offsets on the bus
  localparam logic [7:0] OFS_ACC = 8'h00;
  localparam logic [7:0] OFS_FLG = 8'h04;
  localparam logic [7:0] OFS_COUNT_PAIR = 8'h08;
  localparam logic [7:0] OFS_DE = 8'h0C;
  localparam logic [7:0] OFS_HL = 8'h10;
  localparam logic [7:0] OFS_IXA = 8'h14;
  localparam logic [7:0] OFS_IXB = 8'h18;
  localparam logic [7:0] OFS_PAGE = 8'h1C;
  localparam logic [7:0] OFS_REFR = 8'h20;
  localparam logic [7:0] OFS_CTRL = 8'h24;
  localparam logic [7:0] OFS_CMD = 8'h28;
  localparam logic [7:0] OFS_IDX = 8'h2C;
  localparam logic [7:0] OFS_VEC = 8'h30;
  // flag byte bit positions
  localparam int FLG_S = 7;
  localparam int FLG_Z = 6;
  localparam int FLG_H = 4;
  localparam int FLG_PV = 2;
  localparam int FLG_N = 1;
  localparam int FLG_C = 0;
  // general register slots
  localparam int GP_B = 0;
  localparam int GP_C = 1;
  localparam int GP_D = 2;
  localparam int GP_E = 3;
  localparam int GP_H = 4;
  localparam int GP_L = 5;
  localparam int GP_NUM = 6;
  // values after reset
  localparam logic [7:0] RST_PAGE = 8'h00;
  localparam logic [7:0] RST_REFR = 8'h00;
  localparam logic RST_INT_EN = 1'b0;
  typedef enum logic [1:0] {IM_ZERO, IM_ONE, IM_TWO} cprf_imode_t;
  typedef enum logic [4:0] {
    CMD_NOP, CMD_ADD, CMD_ADC, CMD_SUB, CMD_SBC, CMD_AND, CMD_OR, CMD_XOR,
    CMD_CP, CMD_DECIMAL_ADJUST, CMD_SWAP_AF, CMD_SWAP_GP, CMD_BLK_CMP, CMD_BLK_XFER,
    CMD_BLK_IN, CMD_LD_A_PAGE, CMD_LD_A_REFR, CMD_INT_MODE_ZERO, CMD_INT_MODE_ONE,
    CMD_INT_MODE_TWO
  } cprf_cmd_t;
  function automatic logic parity_even(input logic [7:0] v);
    return ~^v;
  endfunction
endpackage

// file: hw/cprf_alu.sv
`timescale 1ns/1ns
module cprf_alu import cprf_pkg::*; (
  input wire cprf_cmd_t op,
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  input wire logic [7:0] f_in,
  output logic [7:0] res,
  output logic [7:0] f_out
);
  logic cin;
  logic sub;
  logic lo_adj;
  logic hi_adj;
  logic [8:0] sum;
  logic [4:0] half;
  logic [7:0] r;
  logic [7:0] corr;
  logic [7:0] f;
  wire logic ovf_add = (a[7] == b[7]) && (sum[7] != a[7]);
  wire logic ovf_sub = (a[7] != b[7]) && (sum[7] != a[7]);
  always_comb begin
    cin = f_in[FLG_C] & ((op == CMD_ADC) | (op == CMD_SBC));
    sub = (op == CMD_SUB) | (op == CMD_SBC) | (op == CMD_CP);
    lo_adj = f_in[FLG_H] | (a[3:0] > 4'h9);
    hi_adj = f_in[FLG_C] | (a > 8'h99);
    corr = {hi_adj ? 4'h6 : 4'h0, lo_adj ? 4'h6 : 4'h0};
    if (sub) begin
      sum = {1'b0, a} - {1'b0, b} - {8'h00, cin};
      half = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin};
    end else begin
      sum = {1'b0, a} + {1'b0, b} + {8'h00, cin};
      half = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    end
    // bits 5 and 3 pass through untouched
    f = f_in;
    r = a;
    case (op)
      CMD_ADD, CMD_ADC, CMD_SUB, CMD_SBC, CMD_CP: begin
        r = sum[7:0];
        f[FLG_C] = sum[8];
        f[FLG_H] = half[4];
        f[FLG_N] = sub;
        f[FLG_PV] = sub ? ovf_sub : ovf_add;
      end
      CMD_AND, CMD_OR, CMD_XOR: begin
        r = (op == CMD_AND) ? (a & b) : (op == CMD_OR) ? (a | b) : (a ^ b);
        f[FLG_C] = 1'b0;
        f[FLG_H] = (op == CMD_AND);
        f[FLG_N] = 1'b0;
        f[FLG_PV] = parity_even(r);
      end
      CMD_DECIMAL_ADJUST: begin
        r = f_in[FLG_N] ? (a - corr) : (a + corr);
        f[FLG_C] = hi_adj;
        f[FLG_H] = f_in[FLG_N] ? (f_in[FLG_H] & (a[3:0] < 4'h6)) : (a[3:0] > 4'h9);
        f[FLG_PV] = parity_even(r);
      end
      default: begin
        r = a;
      end
    endcase
    if (op inside {CMD_ADD, CMD_ADC, CMD_SUB, CMD_SBC, CMD_CP, CMD_AND, CMD_OR,
                   CMD_XOR, CMD_DECIMAL_ADJUST}) begin
      f[FLG_S] = r[7];
      f[FLG_Z] = (r == 8'h00);
    end
    // compare leaves the accumulator alone
    res = (op == CMD_CP) ? a : r;
    f_out = f;
  end
endmodule // cprf_alu

// file: hw/cprf_regfile.sv
// Design decisions made here: the register addresses and the APB register port.
`timescale 1ns/1ns
// Summary of operation
// - eighteen byte and four word registers
// - only six flag bits change
// - sign flag copies result bit 7
// - zero flag set on all-zero result
// - block compare sets zero on match
// - block input sets zero when count ends
// - logical ops put even parity in PV
// - block compare and block transfer put nonzero count in PV; block input keeps PV
// - page/refresh to accumulator copies interrupt enable
// - arithmetic ops put signed overflow in PV
// - carry flag on carry or borrow
// - half carry from low nibble, used by adjust
// - subtract flag steers decimal adjust
// - six bytes usable as three pairs
// - shadow banks reached only by exchanges
// - interrupt mode 0, 1, 2 by command
// - mode 2 vector high byte from page
// - refresh counter low seven bits count fetches
// - refresh and page drive address low/high
// - refresh never stalls or adds cycles
// - index address is index plus displacement
// - reset clears enable, mode, page, refresh
// - refresh strobe goes with memory request
module cprf_regfile import cprf_pkg::*; #(
  parameter int REFR_CYCLES = REFR_CYC
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic FETCH,
  output logic [15:0] ADDR,
  output logic REFRESH_STROBE_N,
  output logic MEMORY_REQUEST_N,
  output logic [15:0] INT_VECTOR_ADDR
);
  if (REFR_CYCLES < 1 || REFR_CYCLES > 15) begin : g_bad_refr
    $error("REFR_CYCLES must lie between 1 and 15");
  end

  function automatic logic reg_hit(input logic [7:0] a);
    case (a)
      OFS_ACC, OFS_FLG, OFS_COUNT_PAIR, OFS_DE, OFS_HL, OFS_IXA, OFS_IXB, OFS_PAGE,
      OFS_REFR, OFS_CTRL, OFS_CMD, OFS_IDX, OFS_VEC: reg_hit = 1'b1;
      default: reg_hit = 1'b0;
    endcase
  endfunction

  // data registers: main and shadow banks, index registers
  logic [7:0] acc_q;
  logic [7:0] flg_q;
  logic [7:0] acc_sh_q;
  logic [7:0] flg_sh_q;
  logic [7:0] gp_q [GP_NUM];
  logic [7:0] gp_sh_q [GP_NUM];
  logic [15:0] ixa_q;
  logic [15:0] ixb_q;
  logic [15:0] idx_addr_q;
  logic [7:0] veclo_q;
  // control state
  logic [7:0] page_q;
  logic [7:0] refr_q;
  logic [7:0] refr_d;
  cprf_imode_t mode_q;
  logic interrupt_enable_ff_q;
  // bus slave
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  // refresh sequencer
  logic [3:0] rcnt_q;
  logic refresh_strobe_n_q;
  logic memory_request_n_q;
  logic [15:0] addr_q;
  logic [15:0] vec_q;

  // bus decode
  wire logic setup = PSEL & ~PENABLE;
  wire logic wr_en = PSEL & PENABLE & PWRITE & pready_q;
  wire logic wr_acc = wr_en & (PADDR == OFS_ACC);
  wire logic wr_flg = wr_en & (PADDR == OFS_FLG);
  wire logic wr_count_pair = wr_en & (PADDR == OFS_COUNT_PAIR);
  wire logic wr_de = wr_en & (PADDR == OFS_DE);
  wire logic wr_hl = wr_en & (PADDR == OFS_HL);
  wire logic wr_ixa = wr_en & (PADDR == OFS_IXA);
  wire logic wr_ixb = wr_en & (PADDR == OFS_IXB);
  wire logic wr_page = wr_en & (PADDR == OFS_PAGE);
  wire logic wr_refr = wr_en & (PADDR == OFS_REFR);
  wire logic wr_ctrl = wr_en & (PADDR == OFS_CTRL);
  wire logic wr_cmd = wr_en & (PADDR == OFS_CMD);
  wire logic wr_idx = wr_en & (PADDR == OFS_IDX);
  wire logic wr_vec = wr_en & (PADDR == OFS_VEC);

  // command fields
  wire cprf_cmd_t cmd = cprf_cmd_t'(PWDATA[4:0]);
  wire logic [7:0] operand = PWDATA[15:8];

  // register pairs
  wire logic [15:0] count_pair = {gp_q[GP_B], gp_q[GP_C]};
  wire logic [15:0] de = {gp_q[GP_D], gp_q[GP_E]};
  wire logic [15:0] hl = {gp_q[GP_H], gp_q[GP_L]};
  wire logic [15:0] count_pair_dec = count_pair - 16'h0001;
  wire logic [15:0] de_inc = de + 16'h0001;
  wire logic [15:0] hl_inc = hl + 16'h0001;
  wire logic [7:0] b_dec = gp_q[GP_B] - 8'h01;
  wire logic cnt_live = (count_pair_dec != 16'h0000);

  // index address: sign-extended displacement plus chosen base
  wire logic [15:0] idx_base = PWDATA[8] ? ixb_q : ixa_q;
  wire logic [15:0] disp_ext = {{8{PWDATA[7]}}, PWDATA[7:0]};
  wire logic [15:0] idx_sum = idx_base + disp_ext;

  // alu; block compare borrows its compare path
  wire cprf_cmd_t alu_op = (cmd == CMD_BLK_CMP) ? CMD_CP : cmd;
  logic [7:0] alu_res;
  logic [7:0] alu_flg;

  cprf_alu u_alu (
    .op(alu_op),
    .a(acc_q),
    .b(operand),
    .f_in(flg_q),
    .res(alu_res),
    .f_out(alu_flg)
  );

  // block compare keeps carry, takes S/Z/H from the compare
  wire logic [7:0] cmp_flg = {alu_flg[FLG_S], alu_flg[FLG_Z], flg_q[5], alu_flg[FLG_H],
                              flg_q[3], cnt_live, 1'b1, flg_q[FLG_C]};
  // block transfer clears H and N
  wire logic [7:0] xfer_flg = {flg_q[7:5], 1'b0, flg_q[3], cnt_live, 1'b0, flg_q[FLG_C]};
  // block input reports the byte count
  wire logic [7:0] in_flg = {flg_q[FLG_S], (b_dec == 8'h00), flg_q[5:2], 1'b1,
                             flg_q[FLG_C]};

  // load from page or refresh register into the accumulator
  function automatic logic [7:0] ld_flg(input logic [7:0] v, input logic [7:0] f,
                                        input logic en);
    logic [7:0] o;
    o = f;
    o[FLG_S] = v[7];
    o[FLG_Z] = (v == 8'h00);
    o[FLG_H] = 1'b0;
    o[FLG_N] = 1'b0;
    o[FLG_PV] = en;
    return o;
  endfunction

  wire logic is_alu = cmd inside {CMD_ADD, CMD_ADC, CMD_SUB, CMD_SBC, CMD_AND,
                                  CMD_OR, CMD_XOR, CMD_CP, CMD_DECIMAL_ADJUST};

  // read mux; bits above each register read zero
  wire logic [31:0] rd_word =
    (PADDR == OFS_ACC) ? {24'h000000, acc_q} :
    (PADDR == OFS_FLG) ? {24'h000000, flg_q} :
    (PADDR == OFS_COUNT_PAIR) ? {16'h0000, count_pair} :
    (PADDR == OFS_DE) ? {16'h0000, de} :
    (PADDR == OFS_HL) ? {16'h0000, hl} :
    (PADDR == OFS_IXA) ? {16'h0000, ixa_q} :
    (PADDR == OFS_IXB) ? {16'h0000, ixb_q} :
    (PADDR == OFS_PAGE) ? {24'h000000, page_q} :
    (PADDR == OFS_REFR) ? {24'h000000, refr_q} :
    (PADDR == OFS_CTRL) ? {28'h0000000, ~refresh_strobe_n_q, mode_q, interrupt_enable_ff_q} :
    (PADDR == OFS_IDX) ? {16'h0000, idx_addr_q} :
    (PADDR == OFS_VEC) ? {16'h0000, vec_q} :
    32'h00000000;

  // zero wait states: ready in the first access cycle
  always_ff @(posedge CLK) begin
    if (RST) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end else begin
      pready_q <= setup;
      pslverr_q <= setup & ~reg_hit(PADDR);
      if (setup & ~PWRITE) begin
        prdata_q <= rd_word;
      end
    end
  end

  // data registers are kept across reset, as storage is static
  always_ff @(posedge CLK) begin
    if (wr_acc) begin
      acc_q <= PWDATA[7:0];
    end
    if (wr_flg) begin
      flg_q <= PWDATA[7:0];
    end
    if (wr_count_pair) begin
      gp_q[GP_B] <= PWDATA[15:8];
      gp_q[GP_C] <= PWDATA[7:0];
    end
    if (wr_de) begin
      gp_q[GP_D] <= PWDATA[15:8];
      gp_q[GP_E] <= PWDATA[7:0];
    end
    if (wr_hl) begin
      gp_q[GP_H] <= PWDATA[15:8];
      gp_q[GP_L] <= PWDATA[7:0];
    end
    if (wr_ixa) begin
      ixa_q <= PWDATA[15:0];
    end
    if (wr_ixb) begin
      ixb_q <= PWDATA[15:0];
    end
    if (wr_idx) begin
      idx_addr_q <= idx_sum;
    end
    if (wr_vec) begin
      veclo_q <= PWDATA[7:0];
    end
    if (wr_cmd) begin
      if (is_alu) begin
        acc_q <= alu_res;
        flg_q <= alu_flg;
      end
      case (cmd)
        CMD_SWAP_AF: begin
          acc_q <= acc_sh_q;
          acc_sh_q <= acc_q;
          flg_q <= flg_sh_q;
          flg_sh_q <= flg_q;
        end
        CMD_SWAP_GP: begin
          for (int i = 0; i < GP_NUM; i++) begin
            gp_q[i] <= gp_sh_q[i];
            gp_sh_q[i] <= gp_q[i];
          end
        end
        CMD_BLK_CMP: begin
          flg_q <= cmp_flg;
          {gp_q[GP_B], gp_q[GP_C]} <= count_pair_dec;
          {gp_q[GP_H], gp_q[GP_L]} <= hl_inc;
        end
        CMD_BLK_XFER: begin
          flg_q <= xfer_flg;
          {gp_q[GP_B], gp_q[GP_C]} <= count_pair_dec;
          {gp_q[GP_D], gp_q[GP_E]} <= de_inc;
          {gp_q[GP_H], gp_q[GP_L]} <= hl_inc;
        end
        CMD_BLK_IN: begin
          flg_q <= in_flg;
          gp_q[GP_B] <= b_dec;
          {gp_q[GP_H], gp_q[GP_L]} <= hl_inc;
        end
        CMD_LD_A_PAGE: begin
          acc_q <= page_q;
          flg_q <= ld_flg(page_q, flg_q, interrupt_enable_ff_q);
        end
        CMD_LD_A_REFR: begin
          acc_q <= refr_q;
          flg_q <= ld_flg(refr_q, flg_q, interrupt_enable_ff_q);
        end
        default: begin
        end
      endcase
    end
  end

  // a software write to the counter wins over a same-cycle fetch
  assign refr_d = wr_refr ? PWDATA[7:0] :
                  FETCH ? {refr_q[7], refr_q[6:0] + 7'h01} :
                  refr_q;

  always_ff @(posedge CLK) begin
    if (RST) begin
      page_q <= RST_PAGE;
      refr_q <= RST_REFR;
      mode_q <= IM_ZERO;
      interrupt_enable_ff_q <= RST_INT_EN;
    end else begin
      refr_q <= refr_d;
      if (wr_page) begin
        page_q <= PWDATA[7:0];
      end
      if (wr_ctrl) begin
        interrupt_enable_ff_q <= PWDATA[0];
      end
      if (wr_cmd) begin
        case (cmd)
          CMD_INT_MODE_ZERO: mode_q <= IM_ZERO;
          CMD_INT_MODE_ONE: mode_q <= IM_ONE;
          CMD_INT_MODE_TWO: mode_q <= IM_TWO;
          default: mode_q <= mode_q;
        endcase
      end
    end
  end

  // refresh runs beside the fetch; nothing here can hold the decoder
  always_ff @(posedge CLK) begin
    if (RST) begin
      rcnt_q <= 4'h0;
      refresh_strobe_n_q <= 1'b1;
      memory_request_n_q <= 1'b1;
      addr_q <= 16'h0000;
      vec_q <= 16'h0000;
    end else begin
      vec_q <= {page_q, veclo_q};
      if (FETCH) begin
        addr_q <= {page_q, refr_q};
        refresh_strobe_n_q <= 1'b0;
        memory_request_n_q <= 1'b0;
        rcnt_q <= 4'(REFR_CYCLES - 1);
      end else if (rcnt_q != 4'h0) begin
        rcnt_q <= rcnt_q - 4'h1;
      end else begin
        refresh_strobe_n_q <= 1'b1;
        memory_request_n_q <= 1'b1;
      end
    end
  end

  assign PRDATA = prdata_q;
  assign PREADY = pready_q;
  assign PSLVERR = pslverr_q;
  assign ADDR = addr_q;
  assign REFRESH_STROBE_N = refresh_strobe_n_q;
  assign MEMORY_REQUEST_N = memory_request_n_q;
  assign INT_VECTOR_ADDR = vec_q;
endmodule // cprf_regfile

// file: sim/cprf_regfile_assertions.sv
`timescale 1ns/1ns
module cprf_regfile_chk import cprf_pkg::*; #(
  parameter int REFR_CYCLES = REFR_CYC
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic FETCH,
  input wire logic [15:0] ADDR,
  input wire logic REFRESH_STROBE_N,
  input wire logic MEMORY_REQUEST_N,
  input wire logic [15:0] INT_VECTOR_ADDR
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  // one bit wider than the strobe count, so the longest strobe still ends below saturation
  logic [4:0] since_q;
  wire refr_wr = PSEL && PENABLE && PREADY && PWRITE && (PADDR == OFS_REFR);
  wire bad_adr = (PADDR > OFS_VEC) || (PADDR[1:0] != 2'b00);
  // cycles since the last fetch, saturating so a long idle never wraps
  always_ff @(posedge CLK) begin
    if (RST) since_q <= 5'h1F;
    else if (FETCH) since_q <= 5'h01;
    else if (since_q != 5'h1F) since_q <= since_q + 5'h01;
  end
  chk_strobe_pair: assert property (REFRESH_STROBE_N == MEMORY_REQUEST_N)
    else $error("refresh and memory request strobes differ");
  chk_fetch_strobe: assert property (FETCH |=> !REFRESH_STROBE_N && !MEMORY_REQUEST_N)
    else $error("no refresh strobe after fetch");
  chk_strobe_len: assert property (
    (since_q != 5'h00 && since_q <= 5'(REFR_CYCLES)) == !REFRESH_STROBE_N)
    else $error("refresh strobe length wrong");
  chk_refr_count: assert property (FETCH && !refr_wr ##1 FETCH && !refr_wr |=>
    ADDR[6:0] == $past(ADDR[6:0]) + 7'h01 && ADDR[7] == $past(ADDR[7]))
    else $error("refresh counter did not step low seven bits");
  chk_addr_page: assert property (FETCH |=> ADDR[15:8] == INT_VECTOR_ADDR[15:8])
    else $error("page not on high address byte");
  chk_addr_hold: assert property (!FETCH |=> $stable(ADDR))
    else $error("refresh address moved without fetch");
  chk_reset_vals: assert property ($fell(RST) |->
    ADDR == 16'h0000 && REFRESH_STROBE_N && INT_VECTOR_ADDR[15:8] == 8'h00)
    else $error("outputs not cleared by reset");
  chk_unmapped_err: assert property (PSEL && !PENABLE && bad_adr |=> PREADY && PSLVERR)
    else $error("unmapped access not refused");
  chk_err_rdata: assert property (PREADY && PSLVERR && !PWRITE |-> PRDATA == 32'h0)
    else $error("refused read returned data");
  chk_ready_one: assert property (PSEL && !PENABLE |=> PREADY ##1 !PREADY)
    else $error("ready not a single access cycle");
  cov_fetch_b2b: cover property (FETCH ##1 FETCH);
  cov_refused: cover property (PREADY && PSLVERR);
  cov_strobe: cover property ($fell(REFRESH_STROBE_N));
endmodule // cprf_regfile_chk
bind cprf_regfile cprf_regfile_chk #(.REFR_CYCLES(REFR_CYCLES)) cprf_regfile_chk_inst (
  .CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
  .PSLVERR(PSLVERR), .FETCH(FETCH), .ADDR(ADDR), .REFRESH_STROBE_N(REFRESH_STROBE_N),
  .MEMORY_REQUEST_N(MEMORY_REQUEST_N), .INT_VECTOR_ADDR(INT_VECTOR_ADDR));

// file: sim/cprf_fetch_src.sv
`timescale 1ns/1ns
module cprf_fetch_src (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic [3:0] num,
  input wire logic [3:0] gap,
  output logic busy,
  output logic fetch
);
  logic [3:0] left_q;
  logic [3:0] wait_q;
  // one pulse per fetched opcode; gap 0 gives a fetch every cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      left_q <= 4'h0;
      wait_q <= 4'h0;
      fetch <= 1'b0;
    end else begin
      fetch <= 1'b0;
      if (start && left_q == 4'h0) begin
        left_q <= num;
        wait_q <= 4'h0;
      end else if (left_q != 4'h0 && wait_q != 4'h0) begin
        wait_q <= wait_q - 4'h1;
      end else if (left_q != 4'h0) begin
        fetch <= 1'b1;
        left_q <= left_q - 4'h1;
        wait_q <= gap;
      end
    end
  end
  assign busy = (left_q != 4'h0) || fetch;
endmodule // cprf_fetch_src

// file: sim/cpu_register_file_flags_tb.sv
`timescale 1ns/1ns
`define CHK(nm, e, g) begin \
  n_checks++; \
  if ((g) !== (e)) begin \
    num_errors++; \
    $display("[FAIL] %s expected %h seen %h", nm, e, g); \
  end \
end
module cpu_register_file_flags_tb import cprf_pkg::*; ;
  typedef struct packed {cprf_cmd_t op; logic [7:0] a, b, fi, ra, rf;} cprf_row_t;
  logic CLK, RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, FETCH, RSN, MRN, start, busy, er;
  logic [7:0] PADDR;
  logic [31:0] PWDATA, PRDATA, rd;
  logic [15:0] ADDR, IVA;
  logic [3:0] num, gap;
  int num_errors = 0;
  int n_checks = 0;
  int cyc = 0;
  cprf_row_t rows [12] = '{
    '{CMD_ADD, 8'h7F, 8'h01, 8'h00, 8'h80, 8'h94}, '{CMD_ADD, 8'hFF, 8'h01, 8'h00, 8'h00, 8'h51},
    '{CMD_ADC, 8'h01, 8'h01, 8'h01, 8'h03, 8'h00}, '{CMD_SUB, 8'h00, 8'h01, 8'h00, 8'hFF, 8'h93},
    '{CMD_SUB, 8'h80, 8'h01, 8'h00, 8'h7F, 8'h16}, '{CMD_SBC, 8'h05, 8'h01, 8'h01, 8'h03, 8'h02},
    '{CMD_AND, 8'h0F, 8'h03, 8'h00, 8'h03, 8'h14}, '{CMD_OR, 8'h80, 8'h01, 8'h00, 8'h81, 8'h84},
    '{CMD_XOR, 8'h0F, 8'h01, 8'h00, 8'h0E, 8'h00}, '{CMD_CP, 8'h05, 8'h05, 8'h00, 8'h05, 8'h42},
    '{CMD_DECIMAL_ADJUST, 8'h0A, 8'h00, 8'h00, 8'h10, 8'h10},
    '{CMD_DECIMAL_ADJUST, 8'h0F, 8'h00, 8'h12, 8'h09, 8'h06}};
  cprf_regfile cprf_regfile_inst (.CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .FETCH(FETCH), .ADDR(ADDR), .REFRESH_STROBE_N(RSN),
    .MEMORY_REQUEST_N(MRN), .INT_VECTOR_ADDR(IVA));
  cprf_fetch_src cprf_fetch_src_inst (.clk(CLK), .rst(RST), .start(start), .num(num),
    .gap(gap), .busy(busy), .fetch(FETCH));
  initial begin
    CLK = 1'b0;
    forever #2 CLK = ~CLK;
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // every transfer ends with one idle cycle so no strobe is assigned twice in a step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    @(posedge CLK);
    while (PREADY !== 1'b1) @(posedge CLK);
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CLK);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    `CHK(nm, e, rd & m)
  endtask
  task automatic cmd(input cprf_cmd_t c, input logic [7:0] b);
    wr(OFS_CMD, {16'h0, b, 3'b000, c});
  endtask
  task automatic fetch(input logic [3:0] n, input logic [3:0] g);
    start <= 1'b1;
    num <= n;
    gap <= g;
    @(posedge CLK);
    start <= 1'b0;
    @(posedge CLK);
    while (busy === 1'b1) @(posedge CLK);
  endtask
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      finish_test();
    end
  end
  initial begin
    {RST, PSEL, PENABLE, PWRITE, start} = 5'b10000;
    {PADDR, PWDATA, num, gap} = '0;
    repeat (8) @(posedge CLK);
    RST <= 1'b0;
    @(posedge CLK);
    rdc(OFS_PAGE, 32'hFFFFFFFF, 32'h0, "page");
    rdc(OFS_REFR, 32'hFFFFFFFF, 32'h0, "refresh");
    rdc(OFS_CTRL, 32'h7, 32'h0, "ctrl");
    $display("test reset done");
    foreach (rows[i]) begin
      wr(OFS_ACC, {24'h0, rows[i].a});
      wr(OFS_FLG, {24'h0, rows[i].fi | 8'h28});
      cmd(rows[i].op, rows[i].b);
      rdc(OFS_ACC, 32'hFFFFFFFF, {24'h0, rows[i].ra}, "acc");
      rdc(OFS_FLG, 32'hFF, {24'h0, rows[i].rf | 8'h28}, "flags");
    end
    $display("test table done");
    for (int i = 2; i >= 0; i--) begin
      cmd(cprf_cmd_t'(int'(CMD_INT_MODE_ZERO) + i), 8'h00);
      rdc(OFS_CTRL, 32'h6, 32'(i) << 1, "mode");
    end
    wr(OFS_ACC, 32'h11);
    wr(OFS_FLG, 32'h22);
    cmd(CMD_SWAP_AF, 8'h00);
    wr(OFS_ACC, 32'h33);
    wr(OFS_FLG, 32'h44);
    cmd(CMD_SWAP_AF, 8'h00);
    rdc(OFS_ACC, 32'hFF, 32'h11, "swap acc");
    rdc(OFS_FLG, 32'hFF, 32'h22, "swap flags");
    for (int k = 0; k < 3; k++) wr(OFS_COUNT_PAIR + 8'(4 * k), 32'h1234 + 32'(k));
    cmd(CMD_SWAP_GP, 8'h00);
    for (int k = 0; k < 3; k++) wr(OFS_COUNT_PAIR + 8'(4 * k), 32'h0);
    cmd(CMD_SWAP_GP, 8'h00);
    for (int k = 0; k < 3; k++) begin
      rdc(OFS_COUNT_PAIR + 8'(4 * k), 32'hFFFF, 32'h1234 + 32'(k), "swap gp");
    end
    $display("test swap done");
    wr(OFS_COUNT_PAIR, 32'h0002);
    wr(OFS_HL, 32'h0000);
    wr(OFS_ACC, 32'h5A);
    wr(OFS_FLG, 32'h00);
    cmd(CMD_BLK_CMP, 8'h5A);
    rdc(OFS_FLG, 32'h46, 32'h46, "cmp flags");
    rdc(OFS_COUNT_PAIR, 32'hFFFF, 32'h0001, "cmp count");
    wr(OFS_DE, 32'h0100);
    wr(OFS_FLG, 32'h16);
    cmd(CMD_BLK_XFER, 8'h00);
    rdc(OFS_FLG, 32'h16, 32'h00, "xfer flags");
    rdc(OFS_DE, 32'hFFFF, 32'h0101, "xfer dest");
    wr(OFS_COUNT_PAIR, 32'h0155);
    cmd(CMD_BLK_IN, 8'h00);
    rdc(OFS_FLG, 32'h42, 32'h42, "in flags");
    rdc(OFS_COUNT_PAIR, 32'hFFFF, 32'h0055, "in count");
    $display("test block done");
    wr(OFS_PAGE, 32'hA5);
    wr(OFS_CTRL, 32'h1);
    cmd(CMD_LD_A_PAGE, 8'h00);
    rdc(OFS_ACC, 32'hFF, 32'hA5, "acc page");
    rdc(OFS_FLG, 32'hC4, 32'h84, "page flags");
    wr(OFS_CTRL, 32'h0);
    wr(OFS_REFR, 32'h0);
    cmd(CMD_LD_A_REFR, 8'h00);
    rdc(OFS_FLG, 32'hC4, 32'h40, "refr flags");
    wr(OFS_IXA, 32'h1000);
    wr(OFS_IDX, 32'h080);
    rdc(OFS_IDX, 32'hFFFF, 32'h0F80, "index first");
    wr(OFS_IXB, 32'h2000);
    wr(OFS_IDX, 32'h17F);
    rdc(OFS_IDX, 32'hFFFF, 32'h207F, "index second");
    $display("test load index done");
    wr(OFS_PAGE, 32'h12);
    wr(OFS_REFR, 32'h7F);
    fetch(4'd1, 4'd0);
    `CHK("refresh addr", 16'h127F, ADDR)
    rdc(OFS_REFR, 32'hFF, 32'h00, "refresh wrap");
    wr(OFS_REFR, 32'hFF);
    fetch(4'd3, 4'd0);
    `CHK("burst addr", 16'h1281, ADDR)
    rdc(OFS_REFR, 32'hFF, 32'h82, "burst count");
    fetch(4'd2, 4'd3);
    `CHK("strobe active", 2'b00, {RSN, MRN})
    // the strobe stands two cycles after the last fetch
    repeat (2) @(posedge CLK);
    `CHK("strobe idle", 2'b11, {RSN, MRN})
    rdc(OFS_REFR, 32'hFF, 32'h84, "spaced count");
    wr(OFS_VEC, 32'h34);
    repeat (2) @(posedge CLK);
    `CHK("vector", 16'h1234, IVA)
    rdc(OFS_VEC, 32'hFFFF, 32'h1234, "vector reg");
    $display("test refresh done");
    apb(1'b0, 8'h40, 32'h0);
    `CHK("unmapped read", 33'h100000000, {er, rd})
    apb(1'b1, 8'h02, 32'h5);
    `CHK("misaligned", 1'b1, er)
    wr(OFS_ACC, 32'h3C);
    wr(OFS_CTRL, 32'h1);
    cmd(CMD_INT_MODE_ONE, 8'h00);
    RST <= 1'b1;
    repeat (2) @(posedge CLK);
    RST <= 1'b0;
    @(posedge CLK);
    rdc(OFS_CTRL, 32'h7, 32'h0, "ctrl again");
    rdc(OFS_PAGE, 32'hFF, 32'h0, "page again");
    rdc(OFS_ACC, 32'hFF, 32'h3C, "acc kept");
    $display("test second reset done");
    finish_test();
  end
endmodule // cpu_register_file_flags_tb
